//--- src/brx_defs.svh
// constants for the ber receiver register bank and memory window
`ifndef BRX_DEFS_SVH
`define BRX_DEFS_SVH
// ----------------------------------------
// bus shape
// ----------------------------------------
`define BRX_ADDR_W      14
`define BRX_DATA_W      16
`define BRX_STREAMS     32
`define BRX_WIN_BIT     13
`define BRX_STRM_MSB    12
`define BRX_STRM_LSB    8
`define BRX_CHAN_MSB    7
`define BRX_BLK_LSB     5
// ----------------------------------------
// register offsets
// ----------------------------------------
`define BRX_CTRL_OFS    14'h0000
`define BRX_START_OFS   14'h0300
`define BRX_LEN_OFS     14'h0320
`define BRX_BCTL_OFS    14'h0340
`define BRX_ERR_OFS     14'h0360
// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define BRX_START_MSB   7
`define BRX_LEN_MSB     8
`define BRX_SEL_MSB     1
`define BRX_SEL_DATA    2'h0
`define BRX_SEL_CML     2'h1
`define BRX_SEL_CMH     2'h2
`define BRX_RST_VAL     16'h0000
// ----------------------------------------
// stream rate codes and last used channel
// ----------------------------------------
`define BRX_RATE_2M     4'h1
`define BRX_RATE_4M     4'h2
`define BRX_RATE_8M     4'h3
`define BRX_RATE_16M    4'h4
`define BRX_LAST_2M     8'h1F
`define BRX_LAST_4M     8'h3F
`define BRX_LAST_8M     8'h7F
`define BRX_LAST_16M    8'hFF
`endif

//--- src/brx_pkg.sv
// types shared by the ber receiver register bank
package brx_pkg;
    typedef logic [3:0] brx_rate_t;
    typedef enum logic [1:0] {BRX_IDLE, BRX_MEM_WAIT, BRX_ACK} brx_state_e;
    // synchronised host pins
    typedef struct packed {
        logic        cs_n;
        logic        rd_n;
        logic        wr_n;
        logic [13:0] addr;
        logic [15:0] data;
    } brx_pins_s;
    // request into data or connection memory
    typedef struct packed {
        logic        valid;
        logic        wr;
        logic [1:0]  sel;
        logic [4:0]  stream;
        logic [7:0]  chan;
        logic [15:0] wdata;
    } brx_mem_req_s;
endpackage

//--- src/brx_sync.sv
// two-stage synchroniser for the host pins
`timescale 1ns/100ps
`default_nettype none
module brx_sync #(
    parameter int W = 33
) (
    input  wire logic         i_sys_clk,
    input  wire logic         i_arst_n,
    input  wire logic [W-1:0] i_async,
    output var  logic [W-1:0] o_sync
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;

    // ----------------------------------------
    // per-bit flop pair, idle pins read high
    // ----------------------------------------
    for (genvar b = 0; b < W; b++) begin : g_bit
        always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
            if (!i_arst_n) begin
                meta_reg[b] <= 1'b1;
                sync_reg[b] <= 1'b1;
            end else begin
                meta_reg[b] <= i_async[b];
                sync_reg[b] <= meta_reg[b];
            end
        end
    end
    assign o_sync = sync_reg;
endmodule
`default_nettype wire

//--- src/brx_chan_limit.sv
// tells whether a channel is in use at a stream's rate
`timescale 1ns/100ps
`default_nettype none
`include "brx_defs.svh"
module brx_chan_limit (
    input  wire brx_pkg::brx_rate_t i_rate,
    input  wire logic [7:0]         i_chan,
    output var  logic               o_in_range
);
    // ----------------------------------------
    // last usable channel per rate
    // ----------------------------------------
    always_comb begin
        unique case (i_rate)
            `BRX_RATE_2M:  o_in_range = (i_chan <= `BRX_LAST_2M);
            `BRX_RATE_4M:  o_in_range = (i_chan <= `BRX_LAST_4M);
            `BRX_RATE_8M:  o_in_range = (i_chan <= `BRX_LAST_8M);
            `BRX_RATE_16M: o_in_range = (i_chan <= `BRX_LAST_16M);
            default:       o_in_range = 1'b0; // stream unused or reserved rate
        endcase
    end
endmodule
`default_nettype wire

//--- src/brx_regs.sv
// ber receiver registers and memory window of the host port
// Summary of operation
// - per-stream start register, low eight bits give first test channel
// - per-stream test length register, nine low bits set test length
// - per-stream sixteen-bit error count, read only, writes ignored
// - address bit 13 high routes access to data or connection memory if the channel is in use at the stream's rate
// - address bit 13 low decodes as internal register access
// - control bits 1..0 choose data, connection low or connection high memory
// - in window, bits 12..8 are stream and bits 7..0 channel
// - 2.048 Mbps uses channels 0-31, 4.096 Mbps uses 0-63
// - 8.192 Mbps uses channels 0-127, 16.384 Mbps uses 0-255
`timescale 1ns/100ps
`default_nettype none
`include "brx_defs.svh"
module brx_regs (
    input  wire logic                  i_sys_clk,
    input  wire logic                  i_arst_n,
    input  wire logic                  i_cs_n,
    input  wire logic                  i_rd_n,
    input  wire logic                  i_wr_n,
    input  wire logic [13:0]           i_addr,
    input  wire logic [15:0]           i_data,
    output var  logic [15:0]           o_data,
    output var  logic                  o_data_oe,
    output var  logic                  o_ack_n,
    input  wire logic [31:0][3:0]      i_stream_rate,
    input  wire logic [31:0][15:0]     i_err_count,
    output var  logic [31:0][7:0]      o_start_channel,
    output var  logic [31:0][8:0]      o_test_length,
    output var  logic [31:0][15:0]     o_ber_control,
    output var  logic [15:0]           o_ctrl,
    output var  brx_pkg::brx_mem_req_s o_mem_req,
    input  wire logic [15:0]           i_mem_rdata
);
    brx_pkg::brx_pins_s   pins;
    brx_pkg::brx_state_e  state_reg, state_next;
    brx_pkg::brx_mem_req_s mem_reg, mem_next;
    logic [7:0]  start_reg [`BRX_STREAMS];
    logic [7:0]  start_next [`BRX_STREAMS];
    logic [8:0]  len_reg [`BRX_STREAMS];
    logic [8:0]  len_next [`BRX_STREAMS];
    logic [15:0] bctl_reg [`BRX_STREAMS];
    logic [15:0] bctl_next [`BRX_STREAMS];
    logic [15:0] ctrl_reg, ctrl_next;
    logic [15:0] rdata_reg, rdata_next;
    logic        rd_reg, rd_next;
    logic        act_reg, act_next;
    logic        act, go, in_range;
    logic [4:0]  idx, strm;
    logic [7:0]  chan;
    logic [7:0]  blk;

    // ----------------------------------------
    // pin synchronisation
    // ----------------------------------------
    brx_sync #(.W(33)) u_sync (
        .i_sys_clk (i_sys_clk),
        .i_arst_n  (i_arst_n),
        .i_async   ({i_cs_n, i_rd_n, i_wr_n, i_addr, i_data}),
        .o_sync    (pins)
    );

    // access decode helpers
    assign act  = !pins.cs_n && (!pins.rd_n || !pins.wr_n);
    assign go   = (state_reg == brx_pkg::BRX_IDLE) && act && act_reg;
    assign idx  = pins.addr[4:0];
    assign blk  = pins.addr[`BRX_WIN_BIT-1:`BRX_BLK_LSB];
    assign strm = pins.addr[`BRX_STRM_MSB:`BRX_STRM_LSB];
    assign chan = pins.addr[`BRX_CHAN_MSB:0];

    brx_chan_limit u_limit (
        .i_rate     (i_stream_rate[strm]),
        .i_chan     (chan),
        .o_in_range (in_range)
    );

    // ----------------------------------------
    // access sequencing and register writes
    // ----------------------------------------
    always_comb begin
        state_next = state_reg;
        start_next = start_reg;
        len_next   = len_reg;
        bctl_next  = bctl_reg;
        ctrl_next  = ctrl_reg;
        rdata_next = rdata_reg;
        rd_next    = rd_reg;
        act_next   = act;
        mem_next   = '0;
        unique case (state_reg)
            brx_pkg::BRX_IDLE: begin
                if (go) begin
                    rd_next    = pins.wr_n;
                    rdata_next = '0;
                    state_next = brx_pkg::BRX_ACK;
                    if (pins.addr[`BRX_WIN_BIT]) begin
                        if (in_range) begin
                            mem_next.valid  = 1'b1;
                            mem_next.wr     = !pins.wr_n;
                            mem_next.sel    = ctrl_reg[`BRX_SEL_MSB:0];
                            mem_next.stream = strm;
                            mem_next.chan   = chan;
                            mem_next.wdata  = pins.data;
                            if (pins.wr_n) begin
                                state_next = brx_pkg::BRX_MEM_WAIT;
                            end
                        end
                    end else if (!pins.wr_n) begin
                        // upper bits dropped, host keeps them zero
                        if (pins.addr == `BRX_CTRL_OFS) begin
                            ctrl_next = pins.data;
                        end
                        if (blk == `BRX_START_OFS >> `BRX_BLK_LSB) begin
                            start_next[idx] = pins.data[`BRX_START_MSB:0];
                        end
                        if (blk == `BRX_LEN_OFS >> `BRX_BLK_LSB) begin
                            len_next[idx] = pins.data[`BRX_LEN_MSB:0];
                        end
                        if (blk == `BRX_BCTL_OFS >> `BRX_BLK_LSB) begin
                            bctl_next[idx] = pins.data;
                        end
                    end else begin
                        if (pins.addr == `BRX_CTRL_OFS) begin
                            rdata_next = ctrl_reg;
                        end
                        if (blk == `BRX_START_OFS >> `BRX_BLK_LSB) begin
                            rdata_next = {8'h00, start_reg[idx]};
                        end
                        if (blk == `BRX_LEN_OFS >> `BRX_BLK_LSB) begin
                            rdata_next = {7'h00, len_reg[idx]};
                        end
                        if (blk == `BRX_BCTL_OFS >> `BRX_BLK_LSB) begin
                            rdata_next = bctl_reg[idx];
                        end
                        if (blk == `BRX_ERR_OFS >> `BRX_BLK_LSB) begin
                            rdata_next = i_err_count[idx];
                        end
                    end
                end
            end
            brx_pkg::BRX_MEM_WAIT: begin
                rdata_next = i_mem_rdata;
                state_next = brx_pkg::BRX_ACK;
            end
            brx_pkg::BRX_ACK: begin
                if (!act) begin
                    state_next = brx_pkg::BRX_IDLE;
                end
            end
            default: state_next = brx_pkg::BRX_IDLE;
        endcase
    end

    // register update
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_reg <= brx_pkg::BRX_IDLE;
            ctrl_reg  <= `BRX_RST_VAL;
            rdata_reg <= `BRX_RST_VAL;
            rd_reg    <= 1'b0;
            act_reg   <= 1'b0;
            mem_reg   <= '0;
            for (int s = 0; s < `BRX_STREAMS; s++) begin
                start_reg[s] <= 8'h00;
                len_reg[s]   <= 9'h000;
                bctl_reg[s]  <= `BRX_RST_VAL;
            end
        end else begin
            state_reg <= state_next;
            ctrl_reg  <= ctrl_next;
            rdata_reg <= rdata_next;
            rd_reg    <= rd_next;
            act_reg   <= act_next;
            mem_reg   <= mem_next;
            start_reg <= start_next;
            len_reg   <= len_next;
            bctl_reg  <= bctl_next;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign o_ack_n   = !(state_reg == brx_pkg::BRX_ACK);
    assign o_data_oe = (state_reg == brx_pkg::BRX_ACK) && rd_reg && act;
    assign o_data    = rdata_reg;
    assign o_ctrl    = ctrl_reg;
    assign o_mem_req = mem_reg;
    for (genvar s = 0; s < `BRX_STREAMS; s++) begin : g_out
        assign o_start_channel[s] = start_reg[s];
        assign o_test_length[s]   = len_reg[s];
        assign o_ber_control[s]   = bctl_reg[s];
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_arst_n);

    // decoded access kinds seen by the checks
    logic reg_wr, reg_rd, win_go;
    assign reg_wr = go && !pins.addr[`BRX_WIN_BIT] && !pins.wr_n;
    assign reg_rd = go && !pins.addr[`BRX_WIN_BIT] && pins.wr_n;
    assign win_go = go && pins.addr[`BRX_WIN_BIT];

    start_write_a: assert property (
        reg_wr && blk == (`BRX_START_OFS >> `BRX_BLK_LSB)
        |=> start_reg[$past(idx)] == $past(pins.data[7:0]))
        else $error("start channel not stored");
    length_write_a: assert property (
        reg_wr && blk == (`BRX_LEN_OFS >> `BRX_BLK_LSB)
        |=> len_reg[$past(idx)] == $past(pins.data[8:0]))
        else $error("test length not stored");
    err_read_a: assert property (
        reg_rd && blk == (`BRX_ERR_OFS >> `BRX_BLK_LSB)
        |=> o_data == $past(i_err_count[idx]) && !o_ack_n)
        else $error("error count read wrong");
    win_no_reg_a: assert property (
        win_go |=> $stable(ctrl_reg) && o_mem_req.valid == $past(in_range))
        else $error("window access touched registers");
    reg_no_mem_a: assert property (
        go && !pins.addr[`BRX_WIN_BIT] |=> !o_mem_req.valid ##1 !o_mem_req.valid)
        else $error("register access reached memory");
    mem_select_a: assert property (
        o_mem_req.valid |-> o_mem_req.sel == ctrl_reg[1:0])
        else $error("memory select mismatch");
    mem_fields_a: assert property (
        win_go && in_range |=> o_mem_req.stream == $past(strm)
        && o_mem_req.chan == $past(chan) && o_mem_req.wr == $past(!pins.wr_n))
        else $error("stream or channel split wrong");
    low_rates_a: assert property (
        win_go && i_stream_rate[strm] == `BRX_RATE_2M && chan > 8'h1F
        |=> !o_mem_req.valid)
        else $error("unused 2.048 channel reached memory");
    high_rates_a: assert property (
        win_go && i_stream_rate[strm] == `BRX_RATE_8M && chan > 8'h7F
        |=> !o_mem_req.valid)
        else $error("unused 8.192 channel reached memory");
    ack_release_a: assert property (
        !o_ack_n && !act |=> o_ack_n)
        else $error("acknowledge held after strobe release");

    // ----------------------------------------
    // rate limits, register holds and bus drive
    // ----------------------------------------
    mid_rates_a: assert property (
        win_go && i_stream_rate[strm] == `BRX_RATE_4M && chan > `BRX_LAST_4M
        |=> !o_mem_req.valid)
        else $error("unused 4.096 channel reached memory");
    top_rate_a: assert property (
        win_go && i_stream_rate[strm] == `BRX_RATE_16M
        |=> o_mem_req.valid)
        else $error("16.384 channel kept from memory");
    start_hold_a: assert property (
        !(reg_wr && blk == (`BRX_START_OFS >> `BRX_BLK_LSB))
        |=> $stable(o_start_channel))
        else $error("start channel changed without a write");
    length_hold_a: assert property (
        !(reg_wr && blk == (`BRX_LEN_OFS >> `BRX_BLK_LSB))
        |=> $stable(o_test_length))
        else $error("test length changed without a write");
    err_no_write_a: assert property (
        reg_wr && blk == (`BRX_ERR_OFS >> `BRX_BLK_LSB)
        |=> $stable(o_start_channel) && $stable(o_test_length) && $stable(ctrl_reg))
        else $error("error count write changed a register");
    win_read_a: assert property (
        win_go && pins.wr_n && in_range
        |=> o_ack_n ##1 !o_ack_n && o_data == $past(i_mem_rdata))
        else $error("window read data not returned");
    ctrl_write_a: assert property (
        reg_wr && pins.addr == `BRX_CTRL_OFS |=> ctrl_reg == $past(pins.data))
        else $error("control register not stored");
    oe_in_ack_a: assert property (
        o_data_oe |-> !o_ack_n && rd_reg)
        else $error("data driven outside a read acknowledge");
    idle_quiet_a: assert property (
        state_reg == brx_pkg::BRX_IDLE |-> o_ack_n && !o_data_oe)
        else $error("idle port acknowledges or drives data");
    mem_pulse_a: assert property (
        o_mem_req.valid |=> !o_mem_req.valid)
        else $error("memory request longer than one cycle");

    reg_write_c: cover property (reg_wr ##1 !o_ack_n);
    reg_read_c:  cover property (reg_rd ##1 o_data_oe);
    mem_read_c:  cover property (win_go && pins.wr_n && in_range ##2 o_data_oe);
    out_range_c: cover property (win_go && !in_range);
    err_write_c: cover property (reg_wr && blk == (`BRX_ERR_OFS >> `BRX_BLK_LSB));
endmodule
`default_nettype wire

//--- bench/brx_host.sv
// host processor model driving the register port pins
`timescale 1ns/100ps
`default_nettype none
module brx_host (
    input  wire logic        i_sys_clk,
    input  wire logic [15:0] i_rdata,
    input  wire logic        i_ack_n,
    output var  logic        o_cs_n,
    output var  logic        o_rd_n,
    output var  logic        o_wr_n,
    output var  logic [13:0] o_addr,
    output var  logic [15:0] o_wdata
);
    // pins idle at time zero
    initial begin
        o_cs_n = 1'b1;
        o_rd_n = 1'b1;
        o_wr_n = 1'b1;
        o_addr = 14'h0000;
        o_wdata = 16'h0000;
    end

    // one access, held until acknowledge is sampled low or 20 cycles pass, then released
    task automatic access(input logic wr, input logic [13:0] a, input logic [15:0] d,
                          output logic [15:0] q, output logic ok);
        ok = 1'b0;
        q = 16'h0000;
        @(posedge i_sys_clk);
        o_cs_n <= 1'b0;
        o_rd_n <= wr;
        o_wr_n <= !wr;
        // caller picks bit 13 low for registers
        o_addr <= a;
        // callers keep unused upper bits zero
        o_wdata <= wr ? d : ~o_wdata;
        for (int n = 0; n < 20 && !ok; n++) begin
            @(posedge i_sys_clk);
            if (i_ack_n === 1'b0) begin
                ok = 1'b1;
                q = i_rdata;
            end
        end
        // released lines show the inverse, not the last value
        o_cs_n <= 1'b1;
        o_rd_n <= 1'b1;
        o_wr_n <= 1'b1;
        o_addr <= ~a;
        o_wdata <= ~o_wdata;
        repeat (6) @(posedge i_sys_clk);
    endtask
endmodule
`default_nettype wire

//--- bench/testbench.sv
// self-checking bench for the ber receiver register bank
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic                  clk;
    logic                  arst_n;
    logic                  cs_n;
    logic                  rd_n;
    logic                  wr_n;
    logic [13:0]           addr;
    logic [15:0]           wdata;
    logic [15:0]           rdata;
    logic                  oe;
    logic                  ack_n;
    logic [31:0][3:0]      rate;
    logic [31:0][15:0]     errc;
    logic [31:0][7:0]      start_ch;
    logic [31:0][8:0]      test_len;
    logic [31:0][15:0]     ber_ctl;
    logic                  oe_seen;
    logic [15:0]           ctrl;
    brx_pkg::brx_mem_req_s req;
    brx_pkg::brx_mem_req_s last_req;
    logic [15:0]           mem_hold;
    logic [15:0]           mem_rdata;
    int                    n_req;
    int                    n_mismatch;
    int                    compares;

    // clock and stream set-up
    always #25 clk = ~clk;
    initial begin
        clk = 1'b0;
        arst_n = 1'b0;
        n_req = 0;
        n_mismatch = 0;
        compares = 0;
        mem_hold = 16'h0000;
        oe_seen = 1'b0;
        errc = '0;
        errc[7] = 16'hBEEF;
        rate = '0;
        for (int s = 1; s < 5; s++) rate[s] = 4'(s);
    end

    // memory model: answer tags its own request, held until the next request
    assign mem_rdata = req.valid ? {1'b1, req.sel, req.stream, req.chan} : mem_hold;
    always @(posedge clk) begin
        if (req.valid === 1'b1) begin
            mem_hold <= {1'b1, req.sel, req.stream, req.chan};
            last_req <= req;
            n_req <= n_req + 1;
        end
    end

    // data bus drive as seen at the edge where acknowledge is taken
    always @(posedge clk) begin
        if (ack_n === 1'b0 && cs_n === 1'b0) oe_seen <= oe;
    end

    brx_host host_u (.i_sys_clk(clk), .i_rdata(rdata), .i_ack_n(ack_n), .o_cs_n(cs_n),
        .o_rd_n(rd_n), .o_wr_n(wr_n), .o_addr(addr), .o_wdata(wdata));

    brx_regs dut_u (.i_sys_clk(clk), .i_arst_n(arst_n), .i_cs_n(cs_n), .i_rd_n(rd_n),
        .i_wr_n(wr_n), .i_addr(addr), .i_data(wdata), .o_data(rdata), .o_data_oe(oe),
        .o_ack_n(ack_n), .i_stream_rate(rate), .i_err_count(errc),
        .o_start_channel(start_ch), .o_test_length(test_len), .o_ber_control(ber_ctl),
        .o_ctrl(ctrl), .o_mem_req(req), .i_mem_rdata(mem_rdata));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
            n_mismatch++;
        end
    endtask

    // one access, checking acknowledge, read data and memory requests made
    task automatic acc(input logic wr, input logic [13:0] a, input logic [15:0] d,
                       input logic [15:0] exp_q, input int exp_req);
        logic [15:0] q;
        logic        ok;
        int          r0;
        r0 = n_req;
        host_u.access(wr, a, d, q, ok);
        chk({15'h0000, ok}, 16'h0001);
        if (!wr) chk(q, exp_q);
        chk({15'h0000, oe_seen}, {15'h0000, !wr});
        chk({15'h0000, oe}, 16'h0000);
        chk(16'(n_req - r0), 16'(exp_req));
    endtask

    function automatic logic [13:0] win(input int s, input int c);
        return {1'b1, 5'(s), 8'(c)};
    endfunction

    task automatic t_reset_values();
        acc(0, 14'h0300, 16'h0000, 16'h0000, 0);
        acc(0, 14'h0325, 16'h0000, 16'h0000, 0);
        chk(16'(test_len[5]), 16'h0000);
    endtask

    task automatic t_start_length();
        acc(1, 14'h0303, 16'h00A5, 16'h0000, 0);
        acc(0, 14'h0303, 16'h0000, 16'h00A5, 0);
        chk(16'(start_ch[3]), 16'h00A5);
        acc(0, 14'h0300, 16'h0000, 16'h0000, 0);
        acc(1, 14'h033F, 16'h01FF, 16'h0000, 0);
        acc(0, 14'h033F, 16'h0000, 16'h01FF, 0);
        chk(16'(test_len[31]), 16'h01FF);
        acc(1, 14'h0345, 16'h0003, 16'h0000, 0);
        acc(0, 14'h0345, 16'h0000, 16'h0003, 0);
        chk(ber_ctl[5], 16'h0003);
    endtask

    task automatic t_error_count();
        acc(0, 14'h0367, 16'h0000, 16'hBEEF, 0);
        acc(1, 14'h0367, 16'h1234, 16'h0000, 0);
        acc(0, 14'h0367, 16'h0000, 16'hBEEF, 0);
        acc(0, 14'h0200, 16'h0000, 16'h0000, 0);
    endtask

    task automatic t_window_select();
        for (int sel = 0; sel < 3; sel++) begin
            acc(1, 14'h0000, 16'(sel), 16'h0000, 0);
            chk({14'h0000, ctrl[1:0]}, 16'(sel));
            acc(0, win(4, 255), 16'h0000, {1'b1, 2'(sel), 5'd4, 8'hFF}, 1);
        end
        acc(1, win(3, 127), 16'h5A3C, 16'h0000, 1);
        chk(last_req.wdata, 16'h5A3C);
        chk({last_req.wr, last_req.sel, last_req.stream, last_req.chan},
            {1'b1, 2'h2, 5'd3, 8'h7F});
    endtask

    task automatic t_rate_limits();
        int last;
        for (int s = 1; s < 5; s++) begin
            last = (32 << (s - 1)) - 1;
            acc(0, win(s, last), 16'h0000, {1'b1, 2'h2, 5'(s), 8'(last)}, 1);
            if (s < 4) acc(0, win(s, last + 1), 16'h0000, 16'h0000, 0);
        end
        acc(0, win(0, 0), 16'h0000, 16'h0000, 0);
    endtask

    task automatic wrap_up();
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge clk);
        t_reset_values();
        t_start_length();
        t_error_count();
        t_window_select();
        t_rate_limits();
        wrap_up();
    end

    // watchdog: the tests need well under a thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        wrap_up();
    end
endmodule
`default_nettype wire
